// *** rtl/mbxcd_device.sv ***
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - read status opcode 30 returns count bytes
// - read config opcode 10 returns config bytes
// - write config opcode 20 stores count bytes
// - pin io app has one status byte
// - pin io app has three config bytes
// - orientation app returns two status bytes
// - orientation app has two config bytes
// - reset app offset 1 value 20 restores defaults
// - reset app offset 5 suspends or enables pedometer
// - accel front end offset 0 selects range
// - pedometer always sees 8 g resolution
// - source 15 bit 4 drives pin a
// - source 15 bit 5 drives pin b
// - source 15 bit 6 drives pin c
// - source 15 bit 7 gives merged flag
// - source 1A bit 7 gives direction flag
// - pedometer offset 13 sets step coalescing count
// - host watches rising edges on event pins
// - after reset initialise then deep sleep
// - sleep app offset 6 value 00 wakes
// - response echoes selector, done, counts, data
// - host waits for done before reading
module mbxcd_device
  import mbxcd_pkg::*;
#(
  parameter int SAMPLE_DIV = 16 // clocks per accelerometer sample
)(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  mbxcd_link_if.device link, // mailbox link
  input wire logic step_event, // one step detected
  input wire logic activity_event, // activity level changed
  input wire logic motion_event, // autonomous suspend or resume
  input wire logic direction_event, // orientation changed
  output logic clocks_running, // system clocks awake
  output logic ped_suspended, // pedometer held suspended
  output logic [1:0] accel_range // 0: 8 g, 1: 2 g, 2: 4 g
);
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_EXEC = 2'b01,
    ST_RSP = 2'b10
  } mbxcd_phase_t;

  typedef struct packed {
    mbxcd_phase_t phase;
    logic [4:0] idx; // byte index within packet
    logic [7:0] app;
    logic [7:0] op;
    logic [7:0] ofs;
    logic [7:0] cnt;
    logic [7:0] err;
    logic [MAX_BYTES*8-1:0] buf_d; // packet data bytes
    logic [PED_CFG_BYTES*8-1:0] ped_cfg;
    logic [PED_STS_BYTES*8-1:0] ped_sts;
    logic [PIO_CFG_BYTES*8-1:0] pio_cfg;
    logic [ORI_CFG_BYTES*8-1:0] ori_cfg;
    logic [ORI_STS_BYTES*8-1:0] ori_sts;
    logic [MAP_CFG_BYTES*8-1:0] map_cfg;
    logic [RSC_CFG_BYTES*8-1:0] rsc_cfg;
    logic [7:0] afe_cfg;
    logic [7:0] coalesce_cnt;
    logic awake;
    logic suspended;
    logic [1:0] range;
    logic [7:0] div;
    logic tick;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic rsp_last;
    logic cmd_ready;
  } mbxcd_dev_state_t;

  mbxcd_dev_state_t s_reg, s_next;
  logic [PIN_COUNT-1:0] pins;

  // size of the addressed map, zero for an unknown pairing
  function automatic logic [7:0] map_size(input logic [7:0] app, input logic [7:0] op);
    logic [7:0] n;
    n = 8'h00;
    if (op == OP_READ_STATUS) begin
      if (app == APP_PEDOMETER) n = 8'(PED_STS_BYTES);
      else if (app == APP_PIN_IO) n = 8'(PIO_STS_BYTES);
      else if (app == APP_ORIENT) n = 8'(ORI_STS_BYTES);
    end else begin
      if (app == APP_PEDOMETER) n = 8'(PED_CFG_BYTES);
      else if (app == APP_PIN_IO) n = 8'(PIO_CFG_BYTES);
      else if (app == APP_ORIENT) n = 8'(ORI_CFG_BYTES);
      else if (app == APP_PIN_MAP) n = 8'(MAP_CFG_BYTES);
      else if (app == APP_RESET_SUSPEND) n = 8'(RSC_CFG_BYTES);
      else if (app == APP_ACCEL_FE) n = 8'(AFE_CFG_BYTES);
      else if (app == APP_SLEEP_WAKE) n = 8'(SLW_CFG_BYTES);
    end
    return n;
  endfunction : map_size

  // byte pick from a packed byte array, byte 0 in the low lane
  function automatic logic [7:0] pick(input logic [MAX_BYTES*8-1:0] v, input logic [7:0] i);
    return v[i[3:0]*8 +: 8];
  endfunction : pick

  always_comb begin
    logic [7:0] sz;
    logic [7:0] b;
    logic [7:0] k;
    sz = 8'h00;
    b = 8'h00;
    k = 8'h00;
    s_next = s_reg;
    s_next.tick = 1'b0;
    // sample timebase runs only once clocks are woken
    if (s_reg.awake) begin
      if (s_reg.div == 8'(SAMPLE_DIV - 1)) begin
        s_next.div = 8'h00;
        s_next.tick = 1'b1;
      end else begin
        s_next.div = s_reg.div + 8'h01;
      end
    end
    // pedometer events are sticky until the status byte is read; read clear wins over a same-cycle set of a flag read as 1
    if (s_reg.awake && !s_reg.suspended) begin
      if (step_event) begin
        if (s_reg.coalesce_cnt + 8'h01 >= s_reg.ped_cfg[PED_OFS_COALESCE*8 +: 8]) begin
          s_next.coalesce_cnt = 8'h00;
          s_next.ped_sts[BIT_STEP] = 1'b1;
          s_next.ped_sts[BIT_MERGED] = 1'b1;
        end else begin
          s_next.coalesce_cnt = s_reg.coalesce_cnt + 8'h01;
        end
      end
      if (activity_event) begin
        s_next.ped_sts[BIT_ACT] = 1'b1;
        s_next.ped_sts[BIT_MERGED] = 1'b1;
      end
    end
    if (s_reg.awake && motion_event) begin
      s_next.ped_sts[BIT_SUSP] = 1'b1;
      s_next.ped_sts[BIT_MERGED] = 1'b1;
    end
    if (s_reg.awake && direction_event) s_next.ori_sts[BIT_DIR] = 1'b1;
    // packet state machine
    case (s_reg.phase)
      ST_CMD: begin
        s_next.cmd_ready = 1'b1;
        if (link.cmd_valid && s_reg.cmd_ready) begin
          if (s_reg.idx == 5'd0) s_next.app = link.cmd_byte;
          else if (s_reg.idx == 5'd1) s_next.op = link.cmd_byte;
          else if (s_reg.idx == 5'd2) s_next.ofs = link.cmd_byte;
          else if (s_reg.idx == 5'd3) s_next.cnt = link.cmd_byte;
          else s_next.buf_d[4'(s_reg.idx - 5'd4)*8 +: 8] = link.cmd_byte;
          s_next.idx = s_reg.idx + 5'd1;
          if (link.cmd_last) begin
            s_next.phase = ST_EXEC;
            s_next.cmd_ready = 1'b0;
          end
        end
      end
      ST_EXEC: begin
        sz = map_size(s_reg.app, s_reg.op);
        s_next.idx = 5'd0;
        s_next.err = RESP_DONE_OK;
        if (s_reg.op != OP_READ_CFG && s_reg.op != OP_WRITE_CFG && s_reg.op != OP_READ_STATUS) begin
          s_next.err = RESP_ERR_OP;
        end else if (sz == 8'h00) begin
          s_next.err = RESP_ERR_APP;
        end else if ({1'b0, s_reg.ofs} + {1'b0, s_reg.cnt} > {1'b0, sz}) begin
          s_next.err = RESP_ERR_RANGE;
        end else if (s_reg.op == OP_WRITE_CFG) begin
          for (int i = 0; i < MAX_BYTES; i++) begin
            k = 8'(i);
            if (k < s_reg.cnt) begin
              b = pick(s_reg.buf_d, k);
              k = s_reg.ofs + 8'(i);
              if (s_reg.app == APP_PEDOMETER) s_next.ped_cfg[k[3:0]*8 +: 8] = b;
              else if (s_reg.app == APP_PIN_IO) s_next.pio_cfg[k[1:0]*8 +: 8] = b;
              else if (s_reg.app == APP_ORIENT) s_next.ori_cfg[k[0]*8 +: 8] = b;
              else if (s_reg.app == APP_PIN_MAP) s_next.map_cfg[k[2:0]*8 +: 8] = b;
              else if (s_reg.app == APP_ACCEL_FE) begin
                s_next.afe_cfg = b;
                if (b == AFE_RANGE_2G) s_next.range = 2'd1;
                else if (b == AFE_RANGE_4G) s_next.range = 2'd2;
                else s_next.range = 2'd0;
              end else if (s_reg.app == APP_RESET_SUSPEND) begin
                s_next.rsc_cfg[k[2:0]*8 +: 8] = b;
                if (k == RSC_OFS_PED_RESET && b == RSC_VAL_ACTION) begin
                  s_next.ped_cfg = '0;
                  s_next.coalesce_cnt = 8'h00;
                end
                if (k == RSC_OFS_PED_SUSPEND) begin
                  if (b == RSC_VAL_ACTION) s_next.suspended = 1'b1;
                  else if (b == RSC_VAL_ENABLE) s_next.suspended = 1'b0;
                end
              end else if (s_reg.app == APP_SLEEP_WAKE) begin
                if (k == SLW_OFS_WAKE && b == SLW_VAL_WAKE) s_next.awake = 1'b1;
              end
            end
          end
        end
        s_next.phase = ST_RSP;
      end
      default: begin
        // response: selector, done/error, actual count, requested count, data
        if (!s_reg.rsp_valid || link.rsp_ready) begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_last = 1'b0;
          k = (s_reg.err == RESP_DONE_OK && s_reg.op != OP_WRITE_CFG) ? s_reg.cnt : 8'h00;
          if (s_reg.rsp_valid && s_reg.rsp_last) begin
            s_next.rsp_valid = 1'b0;
            s_next.phase = ST_CMD;
            s_next.idx = 5'd0;
            s_next.cmd_ready = 1'b1;
          end else begin
            s_next.idx = s_reg.idx + 5'd1;
            if (s_reg.idx == 5'd0) s_next.rsp_byte = s_reg.app;
            else if (s_reg.idx == 5'd1) s_next.rsp_byte = s_reg.err;
            else if (s_reg.idx == 5'd2) s_next.rsp_byte = k;
            else if (s_reg.idx == 5'd3) s_next.rsp_byte = s_reg.cnt;
            else begin
              b = s_reg.ofs + 8'(s_reg.idx - 5'd4);
              if (s_reg.op == OP_READ_STATUS) begin
                if (s_reg.app == APP_PEDOMETER) begin
                  s_next.rsp_byte = s_reg.ped_sts[b[3:0]*8 +: 8];
                  if (b == 8'h00) s_next.ped_sts[7:0] &= ~s_reg.ped_sts[7:0]; // cleared on read
                end else if (s_reg.app == APP_PIN_IO) s_next.rsp_byte = {5'b0, pins};
                else begin
                  s_next.rsp_byte = s_reg.ori_sts[b[0]*8 +: 8];
                  if (b == 8'h00) s_next.ori_sts[BIT_DIR] &= !s_reg.ori_sts[BIT_DIR];
                end
              end else if (s_reg.app == APP_PEDOMETER) s_next.rsp_byte = s_reg.ped_cfg[b[3:0]*8 +: 8];
              else if (s_reg.app == APP_PIN_IO) s_next.rsp_byte = s_reg.pio_cfg[b[1:0]*8 +: 8];
              else if (s_reg.app == APP_ORIENT) s_next.rsp_byte = s_reg.ori_cfg[b[0]*8 +: 8];
              else if (s_reg.app == APP_PIN_MAP) s_next.rsp_byte = s_reg.map_cfg[b[2:0]*8 +: 8];
              else if (s_reg.app == APP_RESET_SUSPEND) s_next.rsp_byte = s_reg.rsc_cfg[b[2:0]*8 +: 8];
              else s_next.rsp_byte = s_reg.afe_cfg;
            end
            if (s_reg.idx == 5'd3 + 5'(k)) s_next.rsp_last = 1'b1;
          end
        end
      end
    endcase
  end

  // reset: applications initialised, clocks stopped until woken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ori_cfg <= {ORI_CFG_RESET1, ORI_CFG_RESET0};
      s_reg.ori_sts <= {8'h00, ORI_STS_RESET0};
      s_reg.afe_cfg <= AFE_RANGE_8G;
      s_reg.cmd_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // three mapped pins, source pairs at offsets 0, 2, 4
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    mbxcd_flag_map u_map (
      .clk(clk),
      .rst_n(rst_n),
      .sample_tick(s_reg.tick),
      .src_app(s_reg.map_cfg[p*16 +: 8]),
      .src_bit(s_reg.map_cfg[p*16+8 +: 8]),
      .ped_flags(s_reg.ped_sts[7:0]),
      .ori_flags(s_reg.ori_sts[7:0]),
      .pin_out(pins[p])
    );
  end

  assign link.cmd_ready = s_reg.cmd_ready;
  assign link.rsp_valid = s_reg.rsp_valid;
  assign link.rsp_byte = s_reg.rsp_byte;
  assign link.rsp_last = s_reg.rsp_last;
  assign link.event_pins = pins;
  assign clocks_running = s_reg.awake;
  assign ped_suspended = s_reg.suspended;
  assign accel_range = s_reg.range;
endmodule : mbxcd_device

// *** rtl/mbxcd_flag_map.sv ***
`timescale 1ns/10ps
// picks one event flag for an output pin from a (selector, bit) source pair
module mbxcd_flag_map
  import mbxcd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic sample_tick, // new accelerometer sample
  input wire logic [7:0] src_app, // source selector
  input wire logic [7:0] src_bit, // source bit
  input wire logic [7:0] ped_flags, // pedometer status byte 0
  input wire logic [7:0] ori_flags, // orientation status byte 0
  output logic pin_out // mapped pin
);
  typedef struct packed {
    logic pin;
  } mbxcd_fm_state_t;
  mbxcd_fm_state_t s_reg, s_next;

  // refresh only on each sample so the host sees a stable level between samples
  always_comb begin
    s_next = s_reg;
    if (sample_tick) begin
      if (src_app == APP_PEDOMETER) begin
        s_next.pin = ped_flags[src_bit[2:0]];
      end else if (src_app == APP_ORIENT) begin
        s_next.pin = ori_flags[src_bit[2:0]];
      end else begin
        s_next.pin = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin_out = s_reg.pin;
endmodule : mbxcd_flag_map

// *** rtl/mbxcd_host.sv ***
`timescale 1ns/10ps
// host end: apb slave registers order packets over the mailbox link
module mbxcd_host
  import mbxcd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  mbxcd_link_if.host link // mailbox link
);
  typedef struct packed {
    logic [31:0] cmd; // app, op, ofs, cnt (byte 0 = app)
    logic [MAX_BYTES*8-1:0] data; // write data / read response
    logic busy;
    logic done;
    logic [4:0] idx;
    logic [7:0] rsp_hdr;
    logic [2:0] pins_q;
    logic [2:0] edges;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_last;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mbxcd_host_state_t;
  mbxcd_host_state_t s_reg, s_next;

  always_comb begin
    logic [4:0] total;
    total = 5'd4 + ((s_reg.cmd[15:8] == OP_WRITE_CFG) ? s_reg.cmd[28:24] : 5'd0);
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    // rising edges latched sticky, new edge wins over clear
    s_next.pins_q = link.event_pins;
    // apb access answered one cycle after the access phase starts
    if (psel && penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (pwrite) begin
        if (paddr == HREG_CMD) begin
          if (!s_reg.busy) begin
            s_next.cmd = pwdata;
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.idx = 5'd0;
          end else s_next.pslverr = 1'b1;
        end else if (paddr == HREG_DATA_LO) s_next.data[31:0] = pwdata;
        else if (paddr == HREG_DATA_HI) s_next.data[63:32] = pwdata;
        else if (paddr == HREG_DATA_2) s_next.data[95:64] = pwdata;
        else if (paddr == HREG_DATA_3) s_next.data[127:96] = pwdata;
        else if (paddr == HREG_EDGES) s_next.edges = s_reg.edges & ~pwdata[2:0];
        else s_next.pslverr = 1'b1;
      end else begin
        if (paddr == HREG_CMD) s_next.prdata = s_reg.cmd;
        else if (paddr == HREG_DATA_LO) s_next.prdata = s_reg.data[31:0];
        else if (paddr == HREG_DATA_HI) s_next.prdata = s_reg.data[63:32];
        else if (paddr == HREG_DATA_2) s_next.prdata = s_reg.data[95:64];
        else if (paddr == HREG_DATA_3) s_next.prdata = s_reg.data[127:96];
        else if (paddr == HREG_STATUS) s_next.prdata = {30'h0, s_reg.done, s_reg.busy};
        else if (paddr == HREG_RESP) s_next.prdata = {24'h0, s_reg.rsp_hdr};
        else if (paddr == HREG_PINS) s_next.prdata = {29'h0, link.event_pins};
        else if (paddr == HREG_EDGES) s_next.prdata = {29'h0, s_reg.edges};
        else s_next.pslverr = 1'b1;
      end
    end
    s_next.edges = s_next.edges | (link.event_pins & ~s_reg.pins_q);
    // send packet bytes, then collect response
    if (s_reg.busy) begin
      if (s_reg.cmd_valid && link.cmd_ready) begin
        s_next.cmd_valid = 1'b0;
        if (s_reg.cmd_last) s_next.idx = 5'd0;
        else s_next.idx = s_reg.idx + 5'd1;
      end else if (!s_reg.cmd_valid && !s_reg.cmd_last) begin
        s_next.cmd_valid = 1'b1;
        if (s_reg.idx < 5'd4) s_next.cmd_byte = s_reg.cmd[s_reg.idx[1:0]*8 +: 8];
        else s_next.cmd_byte = s_reg.data[4'(s_reg.idx - 5'd4)*8 +: 8];
        s_next.cmd_last = (s_reg.idx == total - 5'd1);
      end
      if (link.rsp_valid) begin
        // done only after the whole response is in
        if (s_reg.idx == 5'd1) s_next.rsp_hdr = link.rsp_byte;
        else if (s_reg.idx >= 5'd4) s_next.data[4'(s_reg.idx - 5'd4)*8 +: 8] = link.rsp_byte;
        s_next.idx = s_reg.idx + 5'd1;
        if (link.rsp_last) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.cmd_last = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign link.cmd_valid = s_reg.cmd_valid;
  assign link.cmd_byte = s_reg.cmd_byte;
  assign link.cmd_last = s_reg.cmd_last;
  assign link.rsp_ready = 1'b1;
endmodule : mbxcd_host

// *** rtl/mbxcd_link_if.sv ***
`timescale 1ns/10ps
// byte-serial mailbox link: host pushes a packet, device returns a response
interface mbxcd_link_if;
  logic cmd_valid; // host presents a command byte
  logic [7:0] cmd_byte; // command byte
  logic cmd_last; // last byte of the packet
  logic cmd_ready; // device takes the byte
  logic rsp_valid; // device presents a response byte
  logic [7:0] rsp_byte; // response byte
  logic rsp_last; // last response byte
  logic rsp_ready; // host takes the response byte
  logic [2:0] event_pins; // mapped event outputs a, b, c
  modport device (input cmd_valid, cmd_byte, cmd_last, rsp_ready,
                  output cmd_ready, rsp_valid, rsp_byte, rsp_last, event_pins);
  modport host (output cmd_valid, cmd_byte, cmd_last, rsp_ready,
                input cmd_ready, rsp_valid, rsp_byte, rsp_last, event_pins);
endinterface : mbxcd_link_if

// *** rtl/mbxcd_pkg.sv ***
package mbxcd_pkg;
  // application selectors
  localparam logic [7:0] APP_PIN_MAP = 8'h03;
  localparam logic [7:0] APP_ACCEL_FE = 8'h06;
  localparam logic [7:0] APP_SLEEP_WAKE = 8'h12;
  localparam logic [7:0] APP_PEDOMETER = 8'h15;
  localparam logic [7:0] APP_RESET_SUSPEND = 8'h17;
  localparam logic [7:0] APP_PIN_IO = 8'h19;
  localparam logic [7:0] APP_ORIENT = 8'h1A;
  // opcodes
  localparam logic [7:0] OP_READ_CFG = 8'h10;
  localparam logic [7:0] OP_WRITE_CFG = 8'h20;
  localparam logic [7:0] OP_READ_STATUS = 8'h30;
  // response second byte
  localparam logic [7:0] RESP_DONE_OK = 8'h80;
  localparam logic [7:0] RESP_ERR_APP = 8'h81;
  localparam logic [7:0] RESP_ERR_OP = 8'h82;
  localparam logic [7:0] RESP_ERR_RANGE = 8'h83;
  // map sizes
  localparam int PED_CFG_BYTES = 16;
  localparam int PED_STS_BYTES = 12;
  localparam int PIO_CFG_BYTES = 3;
  localparam int PIO_STS_BYTES = 1;
  localparam int ORI_CFG_BYTES = 2;
  localparam int ORI_STS_BYTES = 2;
  localparam int MAP_CFG_BYTES = 6;
  localparam int RSC_CFG_BYTES = 8;
  localparam int AFE_CFG_BYTES = 1;
  localparam int SLW_CFG_BYTES = 8;
  localparam int MAX_BYTES = 16;
  // special offsets and values
  localparam logic [7:0] RSC_OFS_PED_RESET = 8'h01;
  localparam logic [7:0] RSC_OFS_PED_SUSPEND = 8'h05;
  localparam logic [7:0] RSC_VAL_ACTION = 8'h20;
  localparam logic [7:0] RSC_VAL_ENABLE = 8'h00;
  localparam logic [7:0] AFE_RANGE_2G = 8'h40;
  localparam logic [7:0] AFE_RANGE_4G = 8'h80;
  localparam logic [7:0] AFE_RANGE_8G = 8'h00;
  localparam logic [7:0] SLW_OFS_WAKE = 8'h06;
  localparam logic [7:0] SLW_VAL_WAKE = 8'h00;
  localparam logic [7:0] PED_OFS_COALESCE = 8'h0D;
  localparam logic [7:0] ORI_CFG_RESET0 = 8'h1E;
  localparam logic [7:0] ORI_CFG_RESET1 = 8'h01;
  localparam logic [7:0] ORI_STS_RESET0 = 8'h06;
  // status flag bit positions in pedometer status byte 0 (BIT_DIR: orientation status byte 0)
  localparam int BIT_ACT = 4;
  localparam int BIT_STEP = 5;
  localparam int BIT_SUSP = 6;
  localparam int BIT_MERGED = 7;
  localparam int BIT_DIR = 7;
  localparam int PIN_COUNT = 3;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  // host command register offsets (apb)
  localparam logic [11:0] HREG_CMD = 12'h000;
  localparam logic [11:0] HREG_DATA_LO = 12'h004;
  localparam logic [11:0] HREG_DATA_HI = 12'h008;
  localparam logic [11:0] HREG_DATA_2 = 12'h00C;
  localparam logic [11:0] HREG_DATA_3 = 12'h010;
  localparam logic [11:0] HREG_STATUS = 12'h014;
  localparam logic [11:0] HREG_RESP = 12'h018;
  localparam logic [11:0] HREG_PINS = 12'h01C;
  localparam logic [11:0] HREG_EDGES = 12'h020;
endpackage : mbxcd_pkg

// *** verif/mbxcd_link_properties.sv ***
`timescale 1ns/10ps
module mbxcd_link_properties
  import mbxcd_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic cmd_valid, // cmd valid
  input wire logic [7:0] cmd_byte, // cmd byte
  input wire logic cmd_last, // cmd end
  input wire logic cmd_ready, // cmd taken
  input wire logic rsp_valid, // rsp valid
  input wire logic [7:0] rsp_byte, // rsp byte
  input wire logic rsp_last, // rsp end
  input wire logic rsp_ready, // rsp taken
  input wire logic [2:0] event_pins // event pins
);
  logic [4:0] ci_reg, ri_reg;
  logic [7:0] app_reg, op_reg, cnt_reg, st_reg, act_reg;
  wire logic ctake = cmd_valid && cmd_ready;
  wire logic rtake = rsp_valid && rsp_ready;
  // byte positions in packet and response; captured fields are only read once their byte has passed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ci_reg <= 5'h00;
      ri_reg <= 5'h00;
    end else begin
      if (ctake) ci_reg <= cmd_last ? 5'h00 : ci_reg + 5'h01;
      if (ctake && ci_reg == 5'h00) app_reg <= cmd_byte;
      if (ctake && ci_reg == 5'h01) op_reg <= cmd_byte;
      if (ctake && ci_reg == 5'h03) cnt_reg <= cmd_byte;
      if (rtake) ri_reg <= rsp_last ? 5'h00 : ri_reg + 5'h01;
      if (rtake && ri_reg == 5'h01) st_reg <= rsp_byte;
      if (rtake && ri_reg == 5'h02) act_reg <= rsp_byte;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pkt_end; ctake && cmd_last; endsequence
  sequence s_exec; !rsp_valid [*2] ##1 rsp_valid; endsequence
  chk_reset_quiet: assert property ($rose(rst_n) |-> !rsp_valid && event_pins == 3'h0) else $error("busy after reset");
  chk_exec_gap: assert property (s_pkt_end |=> s_exec) else $error("exec gap wrong");
  chk_rsp_burst: assert property (rsp_valid && !rsp_last |=> rsp_valid) else $error("response gap");
  chk_app_echo: assert property (rtake && ri_reg == 5'h00 |-> rsp_byte == app_reg) else $error("no echo");
  chk_done_bit: assert property (rtake && ri_reg == 5'h01 |-> rsp_byte[7]) else $error("done bit clear");
  chk_read_count: assert property (rtake && ri_reg == 5'h02 && st_reg == RESP_DONE_OK && op_reg != OP_WRITE_CFG
    |-> rsp_byte == cnt_reg) else $error("bad count");
  chk_err_count: assert property (rtake && ri_reg == 5'h02 && st_reg != RESP_DONE_OK |-> rsp_byte == 8'h00)
    else $error("error count");
  chk_req_echo: assert property (rtake && ri_reg == 5'h03 |-> rsp_byte == cnt_reg) else $error("req count");
  chk_rsp_length: assert property (rtake && rsp_last |-> {3'h0, ri_reg} == act_reg + 8'h03)
    else $error("bad length");
endmodule : mbxcd_link_properties

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb
  import mbxcd_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] ev = 4'h0; // step, activity, motion, direction
  logic clocks_running, ped_suspended;
  logic [1:0] accel_range;
  logic [7:0] cfg [0:31][0:15]; // model config, by selector and offset
  int errors = 0, compares = 0, seed = 52;
  always #20 clk = ~clk;
  mbxcd_link_if mbxcd_link_if_i ();
  mbxcd_host mbxcd_host_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(mbxcd_link_if_i));
  // short sample period so flags reach pins within a few clocks
  mbxcd_device #(.SAMPLE_DIV(4)) mbxcd_device_i (.clk(clk), .rst_n(rst_n), .link(mbxcd_link_if_i),
    .step_event(ev[0]), .activity_event(ev[1]), .motion_event(ev[2]), .direction_event(ev[3]),
    .clocks_running(clocks_running), .ped_suspended(ped_suspended), .accel_range(accel_range));
  mbxcd_link_properties mbxcd_link_properties_i (.clk(clk), .rst_n(rst_n), .cmd_valid(mbxcd_link_if_i.cmd_valid),
    .cmd_byte(mbxcd_link_if_i.cmd_byte), .cmd_last(mbxcd_link_if_i.cmd_last), .cmd_ready(mbxcd_link_if_i.cmd_ready),
    .rsp_valid(mbxcd_link_if_i.rsp_valid), .rsp_byte(mbxcd_link_if_i.rsp_byte), .rsp_last(mbxcd_link_if_i.rsp_last),
    .rsp_ready(mbxcd_link_if_i.rsp_ready), .event_pins(mbxcd_link_if_i.event_pins));
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // pready is registered, so it is looked at settled and taken at the next rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // p holds the packet bytes selector, opcode, offset, count as sent
  task automatic run(input logic [31:0] p, input logic [7:0] code, input logic [31:0] dw);
    logic [7:0] b [0:15];
    for (int i = 0; i < 16; i++) b[i] = (i < 4) ? dw[8*i+:8] : 8'($random(seed));
    for (int i = 0; i < 16; i += 4) apb(1'b1, HREG_DATA_LO + 12'(i), {b[i+3], b[i+2], b[i+1], b[i]});
    apb(1'b1, HREG_CMD, {p[7:0], p[15:8], p[23:16], p[31:24]});
    do begin
      apb(1'b0, HREG_STATUS, 32'h0);
    end while (r[1:0] !== 2'b10);
    apb(1'b0, HREG_RESP, 32'h0);
    chk({24'h0, r[7:0]}, {24'h0, code});
    if (code == RESP_DONE_OK && p[23:16] == OP_WRITE_CFG) begin
      for (int i = 0; i < p[7:0]; i++) cfg[p[28:24]][p[15:8] + i] = b[i];
      if (p[31:8] == 24'h172001 && b[0] == RSC_VAL_ACTION) cfg[21] = '{default: 8'h00};
    end
    if (code == RESP_DONE_OK && p[23:16] == OP_READ_CFG)
      for (int i = 0; i < p[7:0]; i++) begin
        apb(1'b0, HREG_DATA_LO + 12'(4 * (i / 4)), 32'h0);
        chk({24'h0, r[8*(i%4)+:8]}, {24'h0, cfg[p[28:24]][p[15:8] + i]});
      end
  endtask : run
  // pulse events, let three samples pass, then check which mapped pins rose
  task automatic pulse(input logic [3:0] e, input logic [31:0] exp);
    apb(1'b1, HREG_EDGES, 32'h7);
    ev <= e;
    @(posedge clk);
    ev <= 4'h0;
    repeat (12) @(posedge clk);
    apb(1'b0, HREG_EDGES, 32'h0);
    chk(r & 32'h7, exp);
  endtask : pulse
  initial begin
    cfg = '{default: '{default: 8'h00}};
    cfg[26][0] = ORI_CFG_RESET0;
    cfg[26][1] = ORI_CFG_RESET1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, clocks_running}, 32'h0);
    run(32'h1A100002, RESP_DONE_OK, 32'h0);
    run(32'h12200601, RESP_DONE_OK, 32'h0);
    chk({31'h0, clocks_running}, 32'h1);
    run(32'h15200010, RESP_DONE_OK, $random(seed));
    run(32'h15100010, RESP_DONE_OK, 32'h0);
    run(32'h1530000C, RESP_DONE_OK, 32'h0);
    run(32'h1A200002, RESP_DONE_OK, $random(seed));
    run(32'h1A100002, RESP_DONE_OK, 32'h0);
    run(32'h1A300002, RESP_DONE_OK, 32'h0);
    run(32'h19200003, RESP_DONE_OK, $random(seed));
    run(32'h19100003, RESP_DONE_OK, 32'h0);
    run(32'h19300001, RESP_DONE_OK, 32'h0);
    run(32'h07100001, RESP_ERR_APP, 32'h0);
    run(32'h19400001, RESP_ERR_OP, 32'h0);
    run(32'h19200202, RESP_ERR_RANGE, $random(seed));
    run(32'h19100003, RESP_DONE_OK, 32'h0);
    run(32'h17200101, RESP_DONE_OK, 32'h20);
    run(32'h15100010, RESP_DONE_OK, 32'h0);
    run(32'h06200001, RESP_DONE_OK, 32'h40);
    chk({30'h0, accel_range}, 32'h1);
    run(32'h06200001, RESP_DONE_OK, 32'h80);
    chk({30'h0, accel_range}, 32'h2);
    run(32'h17200501, RESP_DONE_OK, 32'h20);
    chk({31'h0, ped_suspended}, 32'h1);
    run(32'h17200501, RESP_DONE_OK, 32'h00);
    chk({31'h0, ped_suspended}, 32'h0);
    for (int k = 0; k < 3; k++) run(32'h03200002 | (k << 9), RESP_DONE_OK, 32'h0415 + (k << 8));
    run(32'h15200D01, RESP_DONE_OK, 32'h2);
    pulse(4'h7, 32'h5);
    run(32'h03200002, RESP_DONE_OK, 32'h071A);
    pulse(4'h9, 32'h3);
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #(40 * 20000);
    errors++;
    tally_and_finish();
  end
endmodule : tb
